/* File: dv/dpt_prog_mem.sv */
// Program memory model holding the instruction words fed to the block
`timescale 1ns/1ps
`default_nettype none
module dpt_prog_mem
(
   input wire logic [3:0] idx,
   output logic [31:0] word
);
   // Transfers never name the counter, and none reads a saved word in user mode
   always_comb
   begin
      case (idx)
         4'h0: word = 32'hE1A01002;
         4'h1: word = 32'hE1A01312;
         4'h2: word = 32'hE1A0F002;
         4'h3: word = 32'hE1A0F312;
         4'h4: word = 32'h01A0F312;
         4'h5: word = 32'hE10F1000;
         4'h6: word = 32'hE129F002;
         4'h7: word = 32'hE169F002;
         4'h8: word = 32'hE328F20F;
         4'h9: word = 32'hE128F002;
         4'hA: word = 32'h010F3000;
         4'hB: word = 32'hE11F1000;
         4'hC: word = 32'hE14F1000;
         default: word = 32'hE1A01002;
      endcase
   end
endmodule : dpt_prog_mem
`default_nettype wire

/* File: dv/testbench.sv */
// Self-checking bench for the cycle timing and status-transfer block
`timescale 1ns/1ps
`default_nettype none
`include "dpt_regs.svh"
module testbench;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'hF;
   logic awready, wready, bvalid, arready, rvalid, done;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata, pm_word;
   dpt_pkg::dpt_kind_t kind;
   logic [7:0] seq = 8'h00;
   logic seq_clr = 1'b0;
   logic [3:0] pm_idx = 4'h0;
   int error_cnt = 0, n_checks = 0, cyc = 0;

   dpt_core uut
   (
      .clk(clk), .reset(reset),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .cycle_kind(kind), .cycle_done(done)
   );
   dpt_prog_mem pm (.idx(pm_idx), .word(pm_word));

   initial forever #12.5 clk = ~clk;

   // Packs the played-out kinds, oldest in the upper bits
   always @(posedge clk)
      if (seq_clr)
         seq <= 8'h00;
      else if (kind != dpt_pkg::kind_none)
         seq <= {seq[5:0], kind};

   task automatic conclude();
      if (error_cnt == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : conclude

   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         error_cnt++;
         conclude();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic got;
      got = 1'b0;
      @(posedge clk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= d;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!got)
      begin
         @(posedge clk);
         if (awvalid && awready)
            awvalid <= 1'b0;
         if (wvalid && wready)
            wvalid <= 1'b0;
         if (bvalid)
         begin
            r = bresp;
            got = 1'b1;
            bready <= 1'b0;
         end
      end
   endtask : axi_wr

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic got;
      got = 1'b0;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!got)
      begin
         @(posedge clk);
         if (arvalid && arready)
            arvalid <= 1'b0;
         if (rvalid)
         begin
            d = rdata;
            r = rresp;
            got = 1'b1;
            rready <= 1'b0;
         end
      end
   endtask : axi_rd

   task automatic wreg(input logic [7:0] a, input logic [31:0] v);
      logic [1:0] r;
      axi_wr(a, v, r);
      chk({30'h0, r}, {30'h0, `DPT_RESP_OKAY});
   endtask : wreg

   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      logic [1:0] r;
      axi_rd(a, d, r);
      chk(d, e);
   endtask : rchk

   task automatic setg(input logic [3:0] g, input logic [31:0] v);
      wreg(`DPT_OFF_GPR_SEL, {28'h0, g});
      wreg(`DPT_OFF_GPR_DATA, v);
   endtask : setg

   task automatic getg(input logic [3:0] g, input logic [31:0] e);
      wreg(`DPT_OFF_GPR_SEL, {28'h0, g});
      rchk(`DPT_OFF_GPR_DATA, e);
   endtask : getg

   // Issues one word from program memory, waits for play-out, then checks kinds and status
   task automatic run(input logic [3:0] i, input logic [10:0] st, input logic [7:0] sq);
      logic [31:0] d;
      logic [1:0] r;
      pm_idx <= i;
      seq_clr <= 1'b1;
      @(posedge clk);
      seq_clr <= 1'b0;
      axi_wr(`DPT_OFF_INSTR, pm_word, r);
      do @(posedge clk); while (!done);
      chk({24'h0, seq}, {24'h0, sq});
      axi_rd(`DPT_OFF_EXEC_STAT, d, r);
      chk({21'h0, d[10:0]}, {21'h0, st});
   endtask : run

   task automatic sc_map();
      logic [31:0] d;
      logic [1:0] r;
      rchk(`DPT_OFF_CUR_STATUS, `DPT_CSW_RESET);
      axi_rd(8'h20, d, r);
      chk({30'h0, r}, {30'h0, `DPT_RESP_SLVERR});
      chk(d, 32'h0);
      axi_wr(8'h20, 32'h1, r);
      chk({30'h0, r}, {30'h0, `DPT_RESP_SLVERR});
   endtask : sc_map

   task automatic sc_timing();
      logic [10:0] st [5] = '{11'h101, 11'h111, 11'h106, 11'h116, 11'h001};
      logic [7:0] sq [5] = '{8'h01, 8'h07, 8'h19, 8'h79, 8'h01};
      for (int i = 0; i < 5; i++)
         run(i[3:0], st[i], sq[i]);
   endtask : sc_timing

   task automatic sc_read();
      run(4'h5, 11'h301, 8'h01);
      getg(4'h1, 32'h000000D3);
      setg(4'h1, 32'h0);
      run(4'hB, 11'h101, 8'h01);
      getg(4'h1, 32'h0);
   endtask : sc_read

   task automatic sc_write();
      setg(4'h2, 32'h600000D1);
      run(4'h6, 11'h301, 8'h01);
      rchk(`DPT_OFF_CUR_STATUS, 32'h600000D1);
      setg(4'h2, 32'hA0000010);
      run(4'h7, 11'h301, 8'h01);
      rchk(`DPT_OFF_SAVED, 32'hA0000010);
      run(4'hC, 11'h301, 8'h01);
      getg(4'h1, 32'hA0000010);
      wreg(`DPT_OFF_CUR_STATUS, 32'h000000D2);
      rchk(`DPT_OFF_SAVED, 32'h0);
      wreg(`DPT_OFF_CUR_STATUS, 32'h000000D1);
      rchk(`DPT_OFF_SAVED, 32'hA0000010);
   endtask : sc_write

   task automatic sc_flags();
      wreg(`DPT_OFF_CUR_STATUS, 32'h000000D3);
      run(4'h8, 11'h301, 8'h01);
      rchk(`DPT_OFF_CUR_STATUS, 32'hF00000D3);
      setg(4'h2, 32'h5FFFFFFF);
      run(4'h9, 11'h301, 8'h01);
      rchk(`DPT_OFF_CUR_STATUS, 32'h500000D3);
   endtask : sc_flags

   task automatic sc_user();
      wreg(`DPT_OFF_CUR_STATUS, 32'h00000010);
      setg(4'h2, 32'h800000D3);
      run(4'h6, 11'h301, 8'h01);
      rchk(`DPT_OFF_CUR_STATUS, 32'h80000010);
      // Zero flag is clear here, so the equal-condition read must do nothing
      setg(4'h3, 32'h12345678);
      run(4'hA, 11'h201, 8'h01);
      getg(4'h3, 32'h12345678);
      rchk(`DPT_OFF_INSTR, 32'h010F3000);
   endtask : sc_user

   initial
   begin
      repeat (16) @(posedge clk);
      reset <= 1'b0;
      repeat (2) @(posedge clk);
      sc_map();
      sc_timing();
      sc_read();
      sc_write();
      sc_flags();
      sc_user();
      conclude();
   end
endmodule : testbench
`default_nettype wire

/* File: rtl/dpt_cond_eval.sv */
// Condition field test against the current flags
`timescale 1ns/1ps
`default_nettype none
module dpt_cond_eval
(
   input wire logic [3:0] cond,
   input wire logic [3:0] flags,
   output logic pass
);
   logic n, z, c, v;
   assign {n, z, c, v} = flags;
   always_comb
   begin
      case (cond)
         4'h0: pass = z;
         4'h1: pass = !z;
         4'h2: pass = c;
         4'h3: pass = !c;
         4'h4: pass = n;
         4'h5: pass = !n;
         4'h6: pass = v;
         4'h7: pass = !v;
         4'h8: pass = c && !z;
         4'h9: pass = !c || z;
         4'hA: pass = (n == v);
         4'hB: pass = (n != v);
         4'hC: pass = !z && (n == v);
         4'hD: pass = z || (n != v);
         4'hE: pass = 1'b1;
         default: pass = 1'b0;
      endcase
   end
endmodule : dpt_cond_eval
`default_nettype wire

/* File: rtl/dpt_core.sv */
// Data-processing cycle timing and status-word transfer unit with AXI4-Lite access
// What this block does
// - Plain data op costs one sequential cycle
// - Register shift adds one internal cycle
// - Counter write costs two S, one N
// - Shift plus counter write: 2S+1N+1I
// - Transfer acts only when condition passes
// - Transfers decoded from test ops, S clear
// - Read copies current or saved word
// - Write fills current or saved word
// - Flags form writes only top nibble
// - User mode cannot change control bits
// - Privileged modes may change every bit
// - Saved word chosen by present mode
//
// The register offsets and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "dpt_regs.svh"
module dpt_core
(
   input wire logic clk,
   input wire logic reset,
   input wire logic [`DPT_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [`DPT_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output dpt_pkg::dpt_kind_t cycle_kind,
   output logic cycle_done
);
   import dpt_pkg::*;

   function automatic logic [2:0] bank_of(input logic [4:0] mode);
      case (mode)
         `DPT_MODE_FIQ: bank_of = 3'h0;
         `DPT_MODE_IRQ: bank_of = 3'h1;
         `DPT_MODE_SVC: bank_of = 3'h2;
         `DPT_MODE_ABT: bank_of = 3'h3;
         `DPT_MODE_UND: bank_of = 3'h4;
         default: bank_of = `DPT_NO_BANK;
      endcase
   endfunction : bank_of

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++)
         if (strb[b])
            r[b*8 +: 8] = nw[b*8 +: 8];
      merge = r;
   endfunction : merge

   function automatic logic [31:0] rot_imm(input logic [11:0] f);
      logic [63:0] d;
      d = {24'h000000, f[`DPT_IMM8], 24'h000000, f[`DPT_IMM8]} >> {f[`DPT_ROT], 1'b0};
      rot_imm = d[31:0];
   endfunction : rot_imm

   logic [31:0] gpr [16];
   logic [31:0] next_gpr [16];
   logic [31:0] saved [`DPT_NBANK];
   logic [31:0] next_saved [`DPT_NBANK];
   logic [31:0] csw, next_csw;
   logic [3:0] gpr_sel, next_gpr_sel;
   logic [31:0] last_instr, next_last_instr;
   logic [10:0] stat, next_stat;
   logic aw_held, next_aw_held, w_held, next_w_held;
   logic [`DPT_ADDR_W-1:0] aw_addr, next_aw_addr;
   logic [31:0] w_data, next_w_data;
   logic [3:0] w_strb, next_w_strb;
   logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
   logic [1:0] next_bresp, next_rresp;
   logic [31:0] next_rdata;

   logic busy, cond_ok, wr_go, issue;
   logic [31:0] instr, src, wmask, wr_val;
   logic is_dp, is_test, is_psr, read_status_instr, msr_full, msr_flg, psr_sel, is_user;
   logic reg_shift, pc_wr, exec_dp;
   logic [2:0] bank;
   logic has_bank;
   logic [3:0] rd;

   assign instr = merge(32'h00000000, w_data, w_strb);
   assign wr_go = aw_held && w_held && !s_axi_bvalid && !(aw_addr == `DPT_OFF_INSTR && busy);
   assign issue = wr_go && (aw_addr == `DPT_OFF_INSTR);
   assign psr_sel = instr[`DPT_PSR_SEL];
   assign rd = instr[`DPT_RD];
   assign is_user = (csw[`DPT_MODE] == `DPT_MODE_USR);
   assign bank = bank_of(csw[`DPT_MODE]);
   assign has_bank = (bank != `DPT_NO_BANK);

   dpt_cond_eval u_cond
   (
      .cond(instr[`DPT_COND]),
      .flags(csw[`DPT_FLAGS]),
      .pass(cond_ok)
   );

   always_comb
   begin
      // Bit 7 set under a register shift means multiply space, not data processing
      is_dp = (instr[`DPT_CLASS] == `DPT_CLASS_DP) &&
              !(!instr[`DPT_IMM_BIT] && instr[`DPT_SHREG_BIT] && instr[`DPT_MUL_BIT]);
      is_test = (instr[`DPT_OPC_TOP] == `DPT_OPC_TEST);
      is_psr = is_dp && is_test && !instr[`DPT_SBIT];
      read_status_instr = is_psr && !instr[`DPT_IMM_BIT] && (instr[`DPT_MRS_MID] == `DPT_MRS_CODE) &&
            (instr[`DPT_LOW12] == 12'h000);
      msr_full = is_psr && !instr[`DPT_IMM_BIT] && (instr[`DPT_MSR_MID] == `DPT_MSR_FULL_CODE) &&
                 (instr[`DPT_LOW8_HI] == 8'h00);
      msr_flg = is_psr && (instr[`DPT_MSR_MID] == `DPT_MSR_FLG_CODE);
      reg_shift = !instr[`DPT_IMM_BIT] && instr[`DPT_SHREG_BIT];
      pc_wr = (rd == `DPT_PC_IDX) && !is_test;
      exec_dp = cond_ok && is_dp && !is_psr;
      // Source register 15 is never named by software, so no prefetch offset here
      src = instr[`DPT_IMM_BIT] ? rot_imm(instr[`DPT_LOW12]) : gpr[instr[`DPT_RM]];
      if (msr_flg)
         wmask = `DPT_MASK_FLAGS;
      else if (!psr_sel && is_user)
         wmask = `DPT_MASK_FLAGS;
      else
         wmask = `DPT_MASK_ALL;
   end

   dpt_cycle_seq u_seq
   (
      .clk(clk),
      .reset(reset),
      .start(issue),
      .want_intl(exec_dp && reg_shift),
      .want_pc(exec_dp && pc_wr),
      .busy(busy),
      .cycle_kind(cycle_kind),
      .cycle_done(cycle_done)
   );

   always_comb
   begin
      next_gpr = gpr;
      next_saved = saved;
      next_csw = csw;
      next_gpr_sel = gpr_sel;
      next_last_instr = last_instr;
      next_stat = stat;
      next_aw_held = aw_held;
      next_aw_addr = aw_addr;
      next_w_held = w_held;
      next_w_data = w_data;
      next_w_strb = w_strb;
      next_bvalid = s_axi_bvalid;
      next_bresp = s_axi_bresp;
      next_rvalid = s_axi_rvalid;
      next_rdata = s_axi_rdata;
      next_rresp = s_axi_rresp;
      wr_val = merge(32'h00000000, w_data, w_strb);
      if (s_axi_awvalid && s_axi_awready)
      begin
         next_aw_held = 1'b1;
         next_aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         next_w_held = 1'b1;
         next_w_data = s_axi_wdata;
         next_w_strb = s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready)
         next_bvalid = 1'b0;
      if (wr_go)
      begin
         next_aw_held = 1'b0;
         next_w_held = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = `DPT_RESP_OKAY;
         case (aw_addr)
            `DPT_OFF_INSTR:
            begin
               next_last_instr = instr;
               next_stat = 11'h000;
               next_stat[`DPT_ST_EXEC] = cond_ok;
               next_stat[`DPT_ST_PSR] = is_psr;
               next_stat[`DPT_ST_S] = (exec_dp && pc_wr) ? 2'h2 : 2'h1;
               next_stat[`DPT_ST_N] = (exec_dp && pc_wr) ? 2'h1 : 2'h0;
               next_stat[`DPT_ST_I] = (exec_dp && reg_shift) ? 2'h1 : 2'h0;
               if (cond_ok && read_status_instr)
               begin
                  if (!psr_sel)
                     next_gpr[rd] = csw;
                  else if (has_bank)
                     next_gpr[rd] = saved[bank];
                  else
                     next_stat[`DPT_ST_BAD] = 1'b1;
               end
               if (cond_ok && (msr_full || msr_flg))
               begin
                  // The state bit is written as given; software keeps it unchanged
                  if (!psr_sel)
                     next_csw = (csw & ~wmask) | (src & wmask);
                  else if (has_bank)
                     next_saved[bank] = (saved[bank] & ~wmask) | (src & wmask);
                  else
                     next_stat[`DPT_ST_BAD] = 1'b1;
               end
            end
            // Direct write for setup and debug; it bypasses user-mode protection
            `DPT_OFF_CUR_STATUS: next_csw = merge(csw, w_data, w_strb);
            `DPT_OFF_GPR_SEL: next_gpr_sel = wr_val[3:0];
            `DPT_OFF_GPR_DATA: next_gpr[gpr_sel] = merge(gpr[gpr_sel], w_data, w_strb);
            `DPT_OFF_SAVED:
               if (has_bank)
                  next_saved[bank] = merge(saved[bank], w_data, w_strb);
            `DPT_OFF_EXEC_STAT: next_bresp = `DPT_RESP_OKAY;
            default: next_bresp = `DPT_RESP_SLVERR;
         endcase
      end
      if (s_axi_rvalid && s_axi_rready)
         next_rvalid = 1'b0;
      if (s_axi_arvalid && s_axi_arready)
      begin
         next_rvalid = 1'b1;
         next_rresp = `DPT_RESP_OKAY;
         case (s_axi_araddr)
            `DPT_OFF_INSTR: next_rdata = last_instr;
            `DPT_OFF_CUR_STATUS: next_rdata = csw;
            `DPT_OFF_GPR_SEL: next_rdata = {28'h0000000, gpr_sel};
            `DPT_OFF_GPR_DATA: next_rdata = gpr[gpr_sel];
            `DPT_OFF_EXEC_STAT: next_rdata = {busy, 20'h00000, stat};
            `DPT_OFF_SAVED: next_rdata = has_bank ? saved[bank] : 32'h00000000;
            default:
            begin
               next_rdata = 32'h00000000;
               next_rresp = `DPT_RESP_SLVERR;
            end
         endcase
      end
      next_awready = !next_aw_held && !next_bvalid;
      next_wready = !next_w_held && !next_bvalid;
      next_arready = !next_rvalid;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         for (int i = 0; i < 16; i++)
            gpr[i] <= 32'h00000000;
         for (int i = 0; i < `DPT_NBANK; i++)
            saved[i] <= 32'h00000000;
         csw <= `DPT_CSW_RESET;
         gpr_sel <= 4'h0;
         last_instr <= 32'h00000000;
         stat <= 11'h000;
         aw_held <= 1'b0;
         aw_addr <= '0;
         w_held <= 1'b0;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `DPT_RESP_OKAY;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `DPT_RESP_OKAY;
      end
      else
      begin
         gpr <= next_gpr;
         saved <= next_saved;
         csw <= next_csw;
         gpr_sel <= next_gpr_sel;
         last_instr <= next_last_instr;
         stat <= next_stat;
         aw_held <= next_aw_held;
         aw_addr <= next_aw_addr;
         w_held <= next_w_held;
         w_data <= next_w_data;
         w_strb <= next_w_strb;
         s_axi_awready <= next_awready;
         s_axi_wready <= next_wready;
         s_axi_bvalid <= next_bvalid;
         s_axi_bresp <= next_bresp;
         s_axi_arready <= next_arready;
         s_axi_rvalid <= next_rvalid;
         s_axi_rdata <= next_rdata;
         s_axi_rresp <= next_rresp;
      end
   end

   chk_cond_fail_quiet: assert property (@(posedge clk) disable iff (reset)
      (issue && !cond_ok) |=> $stable(csw) && !stat[`DPT_ST_EXEC])
      else $error("failed condition still changed the status word");
   chk_sbit_not_psr: assert property (@(posedge clk) disable iff (reset)
      (issue && instr[`DPT_SBIT]) |=> !stat[`DPT_ST_PSR])
      else $error("set-flags op taken as status transfer");
   chk_read_current: assert property (@(posedge clk) disable iff (reset)
      (issue && cond_ok && read_status_instr && !psr_sel) |=> gpr[$past(rd)] == $past(csw))
      else $error("read-status did not copy current word");
   chk_saved_write: assert property (@(posedge clk) disable iff (reset)
      (issue && cond_ok && msr_full && psr_sel && has_bank)
      |=> saved[$past(bank)] == $past(src) && $stable(csw))
      else $error("write-status did not fill saved word");
   chk_flags_only: assert property (@(posedge clk) disable iff (reset)
      (issue && cond_ok && msr_flg && !psr_sel)
      |=> csw[`DPT_FLAGS] == $past(src[`DPT_FLAGS]) && $stable(csw[`DPT_CTRL]))
      else $error("flags-only write touched control bits");
   chk_user_guard: assert property (@(posedge clk) disable iff (reset)
      (issue && is_user) |=> $stable(csw[`DPT_CTRL]))
      else $error("user mode changed control bits");
   chk_priv_full: assert property (@(posedge clk) disable iff (reset)
      (issue && cond_ok && msr_full && !psr_sel && !is_user) |=> csw == $past(src))
      else $error("privileged write did not set whole word");
   chk_fiq_bank: assert property (@(posedge clk) disable iff (reset)
      (csw[`DPT_MODE] == `DPT_MODE_FIQ) |-> bank == 3'h0)
      else $error("fast-interrupt mode picked wrong saved word");
endmodule : dpt_core
`default_nettype wire

/* File: rtl/dpt_cycle_seq.sv */
// Plays out the sequential, internal and non-sequential cycles of one instruction
`timescale 1ns/1ps
`default_nettype none
module dpt_cycle_seq
(
   input wire logic clk,
   input wire logic reset,
   input wire logic start,
   input wire logic want_intl,
   input wire logic want_pc,
   output logic busy,
   output dpt_pkg::dpt_kind_t cycle_kind,
   output logic cycle_done
);
   import dpt_pkg::*;
   dpt_seq_state_t state, next_state;
   dpt_kind_t next_kind;
   logic intl, pc, next_intl, next_pc, next_done;

   always_comb
   begin
      next_state = state;
      next_intl = intl;
      next_pc = pc;
      case (state)
         st_idle:
            if (start)
            begin
               next_state = st_seq1;
               next_intl = want_intl;
               next_pc = want_pc;
            end
         st_seq1:
            if (intl)
               next_state = st_intl;
            else if (pc)
               next_state = st_nseq;
            else
               next_state = st_idle;
         st_intl: next_state = pc ? st_nseq : st_idle;
         // Refill after a counter write: one N then one more S
         st_nseq: next_state = st_seq2;
         st_seq2: next_state = st_idle;
         default: next_state = st_idle;
      endcase
      case (next_state)
         st_seq1, st_seq2: next_kind = kind_seq;
         st_intl: next_kind = kind_intl;
         st_nseq: next_kind = kind_nseq;
         default: next_kind = kind_none;
      endcase
      next_done = (state != st_idle) && (next_state == st_idle);
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         state <= st_idle;
         intl <= 1'b0;
         pc <= 1'b0;
         cycle_kind <= kind_none;
         cycle_done <= 1'b0;
      end
      else
      begin
         state <= next_state;
         intl <= next_intl;
         pc <= next_pc;
         cycle_kind <= next_kind;
         cycle_done <= next_done;
      end
   end

   assign busy = (state != st_idle);

   chk_plain_one_s: assert property (@(posedge clk) disable iff (reset)
      (!busy && start && !want_intl && !want_pc) |=> (cycle_kind == kind_seq) ##1 cycle_done)
      else $error("plain data op did not take one S cycle");
   chk_shift_s_i: assert property (@(posedge clk) disable iff (reset)
      (!busy && start && want_intl && !want_pc)
      |=> (cycle_kind == kind_seq) ##1 (cycle_kind == kind_intl) ##1 cycle_done)
      else $error("register shift op did not take S then I");
   chk_pc_s_n_s: assert property (@(posedge clk) disable iff (reset)
      (!busy && start && !want_intl && want_pc)
      |=> (cycle_kind == kind_seq) ##1 (cycle_kind == kind_nseq) ##1 (cycle_kind == kind_seq)
      ##1 cycle_done)
      else $error("counter write op did not take 2S plus 1N");
   chk_full_cost: assert property (@(posedge clk) disable iff (reset)
      (!busy && start && want_intl && want_pc)
      |=> (busy && cycle_kind == kind_seq) ##1 (busy && cycle_kind == kind_intl)
      ##1 (busy && cycle_kind == kind_nseq) ##1 (busy && cycle_kind == kind_seq)
      ##1 (cycle_done && !busy))
      else $error("shift plus counter write op did not take four cycles");
endmodule : dpt_cycle_seq
`default_nettype wire

/* File: shared/dpt_pkg.sv */
// Types shared by the timing and status-transfer block
`default_nettype none
package dpt_pkg;
   typedef enum logic [4:0]
   {
      st_idle = 5'h01,
      st_seq1 = 5'h02,
      st_intl = 5'h04,
      st_nseq = 5'h08,
      st_seq2 = 5'h10
   } dpt_seq_state_t;
   typedef enum logic [1:0]
   {
      kind_none = 2'h0,
      kind_seq = 2'h1,
      kind_nseq = 2'h2,
      kind_intl = 2'h3
   } dpt_kind_t;
endpackage : dpt_pkg
`default_nettype wire

/* File: shared/dpt_regs.svh */
// Register map, instruction fields and fixed codes of the timing and status-transfer block
`ifndef DPT_REGS_SVH
`define DPT_REGS_SVH
`define DPT_ADDR_W 8
`define DPT_OFF_INSTR 8'h00
`define DPT_OFF_CUR_STATUS 8'h04
`define DPT_OFF_GPR_SEL 8'h08
`define DPT_OFF_GPR_DATA 8'h0C
`define DPT_OFF_EXEC_STAT 8'h10
`define DPT_OFF_SAVED 8'h14
`define DPT_CSW_RESET 32'h000000D3
`define DPT_COND 31:28
`define DPT_CLASS 27:26
`define DPT_IMM_BIT 25
`define DPT_OPC_TOP 24:23
`define DPT_PSR_SEL 22
`define DPT_SBIT 20
`define DPT_MRS_MID 21:16
`define DPT_MSR_MID 21:12
`define DPT_RD 15:12
`define DPT_LOW12 11:0
`define DPT_LOW8_HI 11:4
`define DPT_ROT 11:8
`define DPT_IMM8 7:0
`define DPT_MUL_BIT 7
`define DPT_SHREG_BIT 4
`define DPT_RM 3:0
`define DPT_MODE 4:0
`define DPT_CTRL 27:0
`define DPT_FLAGS 31:28
`define DPT_CLASS_DP 2'h0
`define DPT_OPC_TEST 2'h2
`define DPT_MRS_CODE 6'h0F
`define DPT_MSR_FULL_CODE 10'h29F
`define DPT_MSR_FLG_CODE 10'h28F
`define DPT_PC_IDX 4'hF
`define DPT_MASK_FLAGS 32'hF0000000
`define DPT_MASK_ALL 32'hFFFFFFFF
`define DPT_MODE_USR 5'h10
`define DPT_MODE_FIQ 5'h11
`define DPT_MODE_IRQ 5'h12
`define DPT_MODE_SVC 5'h13
`define DPT_MODE_ABT 5'h17
`define DPT_MODE_UND 5'h1B
`define DPT_NO_BANK 3'h7
`define DPT_NBANK 5
`define DPT_ST_S 1:0
`define DPT_ST_N 3:2
`define DPT_ST_I 5:4
`define DPT_ST_EXEC 8
`define DPT_ST_PSR 9
`define DPT_ST_BAD 10
`define DPT_RESP_OKAY 2'h0
`define DPT_RESP_SLVERR 2'h2
`endif
